// ==== logic/rps_pkg.sv ====
/*
 * Package for the reverse and parallel SIMD execution slice: operation
 * codes, lane widths, register-file geometry and the issue latency.
 * Assumes a 16-entry register file with fixed stack and program counter slots.
 */
`default_nettype none
package rps_pkg;
   // Datapath geometry
   localparam int RPS_WORD_W = 32;
   localparam int RPS_HALF_W = 16;
   localparam int RPS_BYTE_W = 8;
   localparam int RPS_REG_CNT = 16;
   localparam int RPS_REG_AW = 4;
   // Register slots that this slice must never be handed
   localparam logic [3:0] RPS_STACK_POINTER_REG = 4'hd;
   localparam logic [3:0] RPS_PROGRAM_COUNTER_REG = 4'hf;
   // Reset value of every register-file word
   localparam logic [31:0] RPS_REG_RESET = 32'h0000_0000;
   // Issue latency constant, unused by the slice, whose result registers three cycles after a taken issue
   localparam int RPS_RESULT_LATENCY = 1;
   // Condition code field: four bits, flags in N Z C V order
   localparam int RPS_FLAG_N = 3;
   localparam int RPS_FLAG_Z = 2;
   localparam int RPS_FLAG_C = 1;
   localparam int RPS_FLAG_V = 0;
   localparam logic [3:0] RPS_FLAGS_RESET = 4'h0;

   typedef enum logic [3:0] {
      RPS_OP_BYTE_REVERSE_WORD = 4'h0,
      RPS_OP_BYTE_REVERSE_EACH_HALFWORD = 4'h1,
      RPS_OP_BYTE_REVERSE_LOW_HALF_SIGNEXT = 4'h2,
      RPS_OP_BIT_REVERSE_WORD = 4'h3,
      RPS_OP_MOVE_TOP_HALFWORD = 4'h4,
      RPS_OP_SIGNED_DUAL_HALF_ADD = 4'h5,
      RPS_OP_SIGNED_QUAD_BYTE_ADD = 4'h6,
      RPS_OP_SIGNED_HALVING_DUAL_HALF_ADD = 4'h7,
      RPS_OP_SIGNED_HALVING_QUAD_BYTE_ADD = 4'h8,
      RPS_OP_SIGNED_HALVING_ADD_SUB_EXCHANGE = 4'h9,
      RPS_OP_SIGNED_HALVING_SUB_ADD_EXCHANGE = 4'ha,
      RPS_OP_SIGNED_HALVING_DUAL_HALF_SUB = 4'hb,
      RPS_OP_SIGNED_HALVING_QUAD_BYTE_SUB = 4'hc,
      RPS_OP_SIGNED_DUAL_HALF_SUB = 4'hd,
      RPS_OP_SIGNED_QUAD_BYTE_SUB = 4'he
   } rps_op_t;

   typedef enum logic [3:0] {
      RPS_CC_EQ = 4'h0, RPS_CC_NE = 4'h1, RPS_CC_CS = 4'h2, RPS_CC_CC = 4'h3,
      RPS_CC_MI = 4'h4, RPS_CC_PL = 4'h5, RPS_CC_VS = 4'h6, RPS_CC_VC = 4'h7,
      RPS_CC_HI = 4'h8, RPS_CC_LS = 4'h9, RPS_CC_GE = 4'ha, RPS_CC_LT = 4'hb,
      RPS_CC_GT = 4'hc, RPS_CC_LE = 4'hd, RPS_CC_AL = 4'he, RPS_CC_NV = 4'hf
   } rps_cond_t;
endpackage
`default_nettype wire

// ==== logic/rps_regfile.sv ====
/*
 * Small register file for the execution slice: two registered read ports,
 * one write port and a synchronous clear.
 * Assumes a single clock; a read of a word written in the same cycle sees
 * the old value.
 */
`timescale 1ns/1ns
`default_nettype none
module rps_regfile
   import rps_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [RPS_REG_AW-1:0] i_rd_a_addr,
   input wire logic [RPS_REG_AW-1:0] i_rd_b_addr,
   output logic [RPS_WORD_W-1:0] o_rd_a_data,
   output logic [RPS_WORD_W-1:0] o_rd_b_data,
   input wire logic i_wr_en,
   input wire logic [RPS_REG_AW-1:0] i_wr_addr,
   input wire logic [RPS_WORD_W-1:0] i_wr_data
);
   logic [RPS_WORD_W-1:0] mem [RPS_REG_CNT];

   // Storage with clear; the clear keeps reads defined after reset
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         for (int k = 0; k < RPS_REG_CNT; k++) begin
            mem[k] <= RPS_REG_RESET;
         end
      end else if (i_wr_en) begin
         mem[i_wr_addr] <= i_wr_data;
      end
   end

   // Read data come out of registers
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_rd_a_data <= RPS_REG_RESET;
         o_rd_b_data <= RPS_REG_RESET;
      end else begin
         o_rd_a_data <= mem[i_rd_a_addr];
         o_rd_b_data <= mem[i_rd_b_addr];
      end
   end
endmodule
`default_nettype wire

// ==== logic/rps_alu.sv ====
/*
 * Execution slice for byte and bit reversal, move-top and the signed
 * parallel halfword and byte operations, with its own register file and
 * condition check.
 * Assumes the decoder issues one operation at a time, holds i_issue for one
 * cycle and supplies the current status flags on i_flags.
 */
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Word byte reversal swaps all four bytes
// - Swap bytes inside each halfword independently
// - Swap low-half bytes, sign-extend to 32 bits
// - Operand bit i goes to bit 31-i
// - These operations never change condition flags
// - Move-top writes immediate into bits 31:16
// - Move-top keeps low half and flags
// - Signed add of each halfword pair
// - Signed add of each byte pair
// - Halfword sums halved by right shift
// - Byte sums halved by right shift
// - Top gets half sum, bottom half difference
// - Bottom gets half difference, top half sum
// - Halfword differences halved by right shift
// - Byte differences halved by right shift
// - Signed subtract of each halfword pair
// - Signed subtract of each byte pair
// - Failed condition suppresses the destination write
// - Omitted destination writes first operand register
module rps_alu
   import rps_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_issue,
   input wire logic [3:0] i_op,
   input wire logic [3:0] i_cond,
   input wire logic [3:0] i_flags,
   input wire logic [RPS_REG_AW-1:0] i_first_operand_reg,
   input wire logic [RPS_REG_AW-1:0] i_second_operand_reg,
   input wire logic [RPS_REG_AW-1:0] i_dest_reg,
   input wire logic i_dest_present,
   input wire logic [15:0] i_imm16,
   input wire logic [RPS_REG_AW-1:0] i_peek_reg,
   output logic [RPS_WORD_W-1:0] o_peek_data,
   output logic o_busy,
   output logic o_done,
   output logic o_wrote,
   output logic o_illegal,
   output logic [RPS_WORD_W-1:0] o_result,
   output logic [3:0] o_flags
);
   typedef enum logic [2:0] {
      RPS_ST_IDLE = 3'b001,
      RPS_ST_READ = 3'b010,
      RPS_ST_EXEC = 3'b100
   } rps_state_t;

   rps_state_t state;
   rps_op_t op_q;
   logic [3:0] cond_q;
   logic [RPS_REG_AW-1:0] dest_q;
   logic [RPS_REG_AW-1:0] rd_a_addr;
   logic [RPS_REG_AW-1:0] rd_b_addr;
   logic [RPS_REG_AW-1:0] first_q;
   logic [RPS_REG_AW-1:0] second_q;
   logic [15:0] imm_q;
   logic [RPS_WORD_W-1:0] opa;
   logic [RPS_WORD_W-1:0] opb;
   logic [RPS_WORD_W-1:0] next_result;
   logic cond_pass;
   logic bad_reg;
   logic wr_en;

   // Halfword lane: form at 17 bits so halving never overflows
   function automatic logic [15:0] half_lane(input logic [15:0] a, input logic [15:0] b,
                                            input logic sub, input logic halve);
      logic [16:0] wide;
      wide = sub ? ({a[15], a} - {b[15], b}) : ({a[15], a} + {b[15], b});
      half_lane = halve ? wide[16:1] : wide[15:0];
   endfunction

   // Byte lane: same scheme at 9 bits
   function automatic logic [7:0] byte_lane(input logic [7:0] a, input logic [7:0] b,
                                           input logic sub, input logic halve);
      logic [8:0] wide;
      wide = sub ? ({a[7], a} - {b[7], b}) : ({a[7], a} + {b[7], b});
      byte_lane = halve ? wide[8:1] : wide[7:0];
   endfunction

   // Condition evaluation on N Z C V
   function automatic logic cond_ok(input logic [3:0] cc, input logic [3:0] f);
      logic n;
      logic z;
      logic c;
      logic v;
      n = f[RPS_FLAG_N];
      z = f[RPS_FLAG_Z];
      c = f[RPS_FLAG_C];
      v = f[RPS_FLAG_V];
      unique case (cc)
         RPS_CC_EQ: cond_ok = z;
         RPS_CC_NE: cond_ok = !z;
         RPS_CC_CS: cond_ok = c;
         RPS_CC_CC: cond_ok = !c;
         RPS_CC_MI: cond_ok = n;
         RPS_CC_PL: cond_ok = !n;
         RPS_CC_VS: cond_ok = v;
         RPS_CC_VC: cond_ok = !v;
         RPS_CC_HI: cond_ok = c && !z;
         RPS_CC_LS: cond_ok = !c || z;
         RPS_CC_GE: cond_ok = (n == v);
         RPS_CC_LT: cond_ok = (n != v);
         RPS_CC_GT: cond_ok = !z && (n == v);
         RPS_CC_LE: cond_ok = z || (n != v);
         default: cond_ok = 1'b1;
      endcase
   endfunction

   function automatic logic is_reserved_reg(input logic [RPS_REG_AW-1:0] r);
      is_reserved_reg = (r == RPS_STACK_POINTER_REG) || (r == RPS_PROGRAM_COUNTER_REG);
   endfunction

   // Move-top reads its destination so the low half can be kept; after issue
   // the latched fields are used, so the decoder need not hold its outputs
   always_comb begin
      if (state == RPS_ST_IDLE) begin
         rd_a_addr = (i_op == RPS_OP_MOVE_TOP_HALFWORD)
                     ? (i_dest_present ? i_dest_reg : i_first_operand_reg)
                     : i_first_operand_reg;
         rd_b_addr = i_second_operand_reg;
      end else begin
         rd_a_addr = (op_q == RPS_OP_MOVE_TOP_HALFWORD) ? dest_q : first_q;
         rd_b_addr = second_q;
      end
   end

   rps_regfile u_regfile (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_rd_a_addr(rd_a_addr),
      .i_rd_b_addr(rd_b_addr),
      .o_rd_a_data(opa),
      .o_rd_b_data(opb),
      .i_wr_en(wr_en),
      .i_wr_addr(dest_q),
      .i_wr_data(next_result)
   );

   // Issue control: idle, wait for registered reads, then execute
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state <= RPS_ST_IDLE;
      end else begin
         unique case (state)
            RPS_ST_IDLE: if (i_issue) state <= RPS_ST_READ;
            RPS_ST_READ: state <= RPS_ST_EXEC;
            RPS_ST_EXEC: state <= RPS_ST_IDLE;
         endcase
      end
   end

   // Latch the operation when it is taken
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         op_q <= RPS_OP_BYTE_REVERSE_WORD;
         cond_q <= 4'he;
         dest_q <= 4'h0;
         first_q <= 4'h0;
         second_q <= 4'h0;
         imm_q <= 16'h0000;
         bad_reg <= 1'b0;
         cond_pass <= 1'b0;
      end else if (state == RPS_ST_IDLE && i_issue) begin
         op_q <= rps_op_t'(i_op);
         cond_q <= i_cond;
         dest_q <= i_dest_present ? i_dest_reg : i_first_operand_reg;
         first_q <= i_first_operand_reg;
         second_q <= i_second_operand_reg;
         imm_q <= i_imm16;
         cond_pass <= cond_ok(i_cond, i_flags);
         // The decoder is trusted to keep these out; a slip is only flagged
         bad_reg <= is_reserved_reg(i_first_operand_reg)
                    || is_reserved_reg(i_second_operand_reg)
                    || (i_dest_present && is_reserved_reg(i_dest_reg));
      end
   end

   // Result selection
   always_comb begin
      next_result = opa;
      unique case (op_q)
         RPS_OP_BYTE_REVERSE_WORD:
            next_result = {opa[7:0], opa[15:8], opa[23:16], opa[31:24]};
         RPS_OP_BYTE_REVERSE_EACH_HALFWORD:
            next_result = {opa[23:16], opa[31:24], opa[7:0], opa[15:8]};
         RPS_OP_BYTE_REVERSE_LOW_HALF_SIGNEXT:
            next_result = {{16{opa[7]}}, opa[7:0], opa[15:8]};
         RPS_OP_BIT_REVERSE_WORD: begin
            for (int k = 0; k < RPS_WORD_W; k++) begin
               next_result[k] = opa[RPS_WORD_W-1-k];
            end
         end
         RPS_OP_MOVE_TOP_HALFWORD:
            next_result = {imm_q, opa[15:0]};
         RPS_OP_SIGNED_DUAL_HALF_ADD:
            next_result = {half_lane(opa[31:16], opb[31:16], 1'b0, 1'b0),
                           half_lane(opa[15:0], opb[15:0], 1'b0, 1'b0)};
         RPS_OP_SIGNED_HALVING_DUAL_HALF_ADD:
            next_result = {half_lane(opa[31:16], opb[31:16], 1'b0, 1'b1),
                           half_lane(opa[15:0], opb[15:0], 1'b0, 1'b1)};
         RPS_OP_SIGNED_HALVING_ADD_SUB_EXCHANGE:
            next_result = {half_lane(opa[31:16], opb[15:0], 1'b0, 1'b1),
                           half_lane(opa[15:0], opb[31:16], 1'b1, 1'b1)};
         RPS_OP_SIGNED_HALVING_SUB_ADD_EXCHANGE:
            next_result = {half_lane(opa[15:0], opb[31:16], 1'b0, 1'b1),
                           half_lane(opa[31:16], opb[15:0], 1'b1, 1'b1)};
         RPS_OP_SIGNED_HALVING_DUAL_HALF_SUB:
            next_result = {half_lane(opa[31:16], opb[31:16], 1'b1, 1'b1),
                           half_lane(opa[15:0], opb[15:0], 1'b1, 1'b1)};
         RPS_OP_SIGNED_DUAL_HALF_SUB:
            next_result = {half_lane(opa[31:16], opb[31:16], 1'b1, 1'b0),
                           half_lane(opa[15:0], opb[15:0], 1'b1, 1'b0)};
         RPS_OP_SIGNED_QUAD_BYTE_ADD,
         RPS_OP_SIGNED_HALVING_QUAD_BYTE_ADD,
         RPS_OP_SIGNED_HALVING_QUAD_BYTE_SUB,
         RPS_OP_SIGNED_QUAD_BYTE_SUB: begin
            // share one loop of independent byte lanes
            for (int k = 0; k < 4; k++) begin
               next_result[k*8 +: 8] = byte_lane(opa[k*8 +: 8], opb[k*8 +: 8],
                  (op_q == RPS_OP_SIGNED_HALVING_QUAD_BYTE_SUB)
                  || (op_q == RPS_OP_SIGNED_QUAD_BYTE_SUB),
                  (op_q == RPS_OP_SIGNED_HALVING_QUAD_BYTE_ADD)
                  || (op_q == RPS_OP_SIGNED_HALVING_QUAD_BYTE_SUB));
            end
         end
         default: next_result = opa;
      endcase
   end

   // Write only when the condition held and the op code is known
   assign wr_en = (state == RPS_ST_EXEC) && cond_pass && (op_q <= RPS_OP_SIGNED_QUAD_BYTE_SUB);

   // Completion reporting, all from flip-flops
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_done <= 1'b0;
         o_wrote <= 1'b0;
         o_illegal <= 1'b0;
         o_result <= RPS_REG_RESET;
      end else begin
         o_done <= (state == RPS_ST_EXEC);
         o_wrote <= wr_en;
         o_illegal <= (state == RPS_ST_EXEC) && bad_reg;
         if (wr_en) begin
            o_result <= next_result;
         end
      end
   end

   // Flags pass through one register unchanged: nothing in this slice alters them
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_flags <= RPS_FLAGS_RESET;
      end else begin
         o_flags <= i_flags;
      end
   end

   // Debug peek port shadows writes to the watched register
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_peek_data <= RPS_REG_RESET;
      end else if (wr_en && (dest_q == i_peek_reg)) begin
         o_peek_data <= next_result;
      end
   end

   assign o_busy = (state != RPS_ST_IDLE);
endmodule
`default_nettype wire

// ==== tb/rps_alu_sva.sv ====
/*
 Port checker for the execution slice: issue timing, pulse shapes,
 condition suppression and flag pass-through.
 Assumes one clock and the synchronous active-high reset of the slice.
 */
`timescale 1ns/1ns
`default_nettype none
module rps_alu_sva
   import rps_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_issue,
   input wire logic [3:0] i_cond,
   input wire logic [3:0] i_flags,
   input wire logic o_busy,
   input wire logic o_done,
   input wire logic o_wrote,
   input wire logic o_illegal,
   input wire logic [31:0] o_result,
   input wire logic [3:0] o_flags
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);

   // Taken issues finish on a fixed beat, busy covers the two work cycles
   a_done_exact_time: assert property (i_issue && !o_busy |-> ##3 o_done)
      else $error("done not three cycles after issue");
   a_no_early_done: assert property (i_issue && !o_busy |=> !o_done [*2])
      else $error("done came early");
   a_busy_two_cycles: assert property (i_issue && !o_busy |=> o_busy [*2] ##1 !o_busy)
      else $error("busy window wrong");
   a_done_single_pulse: assert property (o_done |=> !o_done)
      else $error("done longer than one cycle");
   a_wrote_with_done: assert property (o_wrote |-> o_done)
      else $error("wrote without done");
   a_illegal_with_done: assert property (o_illegal |-> o_done)
      else $error("illegal without done");
   // Result only moves on a write, so a suppressed write leaves it alone
   a_result_holds: assert property (!$past(i_sys_rst) && $changed(o_result) |-> o_wrote)
      else $error("result changed without a write");
   a_always_writes: assert property (i_issue && !o_busy && i_cond == RPS_CC_AL |-> ##3 o_wrote)
      else $error("unconditional op did not write");
   a_cond_fail_quiet: assert property (i_issue && !o_busy && i_cond == RPS_CC_EQ && !i_flags[RPS_FLAG_Z]
      |-> ##3 o_done && !o_wrote)
      else $error("failed condition still wrote");
   // Flags are only delayed, never altered
   a_flags_untouched: assert property (!$past(i_sys_rst) |-> o_flags == $past(i_flags))
      else $error("flags altered");
endmodule
bind rps_alu rps_alu_sva u_sva (.i_clk, .i_sys_rst, .i_issue, .i_cond, .i_flags, .o_busy,
   .o_done, .o_wrote, .o_illegal, .o_result, .o_flags);
`default_nettype wire

// ==== tb/rps_decoder_model.sv ====
/*
 Decoder stand-in: turns a one-cycle request into an issue pulse.
 Assumes the bench holds the operand fields steady until done.
 */
`timescale 1ns/1ns
`default_nettype none
module rps_decoder_model
   import rps_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_go,
   input wire logic i_busy,
   input wire logic [3:0] i_first,
   input wire logic [3:0] i_second,
   input wire logic [3:0] i_dest,
   output logic o_issue
);
   logic legal;
   // Reserved slots never reach the slice from a well-formed stream
   assign legal = !(i_first inside {RPS_STACK_POINTER_REG, RPS_PROGRAM_COUNTER_REG})
      && !(i_second inside {RPS_STACK_POINTER_REG, RPS_PROGRAM_COUNTER_REG})
      && !(i_dest inside {RPS_STACK_POINTER_REG, RPS_PROGRAM_COUNTER_REG});
   // Issue only while the slice is idle, one pulse per request; a request during busy is dropped
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_issue <= 1'h0;
      end else begin
         o_issue <= i_go && !i_busy && legal;
      end
   end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
/*
 Self-checking bench for the execution slice, issuing through the decoder
 stand-in and tracking a shadow register file.
 Assumes registers clear to zero at reset.
 */
`timescale 1ns/1ns
`default_nettype none
module tb;
   import rps_pkg::*;
   logic clk = 1'h0, rst = 1'h1, go = 1'h0, dp = 1'h0, issue;
   logic [3:0] op = 4'h0, cc = 4'he, fl = 4'h0, ra = 4'h0, rb = 4'h0, rd = 4'h0, pk = 4'h0;
   logic [15:0] imm = 16'h0;
   logic [31:0] sh [16];
   logic [31:0] peek, res;
   logic busy, done, wrote, illegal;
   logic [3:0] flo;
   int errors = 0, samples_checked = 0, cyc = 0;

   rps_decoder_model u_dec (.i_clk(clk), .i_sys_rst(rst), .i_go(go), .i_busy(busy),
      .i_first(ra), .i_second(rb), .i_dest(rd), .o_issue(issue));
   rps_alu DUT (.i_clk(clk), .i_sys_rst(rst), .i_issue(issue), .i_op(op), .i_cond(cc),
      .i_flags(fl), .i_first_operand_reg(ra), .i_second_operand_reg(rb), .i_dest_reg(rd),
      .i_dest_present(dp), .i_imm16(imm), .i_peek_reg(pk), .o_peek_data(peek), .o_busy(busy),
      .o_done(done), .o_wrote(wrote), .o_illegal(illegal), .o_result(res), .o_flags(flo));

   task automatic tally_and_finish();
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   function automatic logic [15:0] hv(input int z);
      return z[16:1];
   endfunction
   // Reference lanes are computed wide in int, then halved by arithmetic shift
   function automatic logic [31:0] model(input logic [3:0] o, input logic [31:0] a, b, d,
      input logic [15:0] m);
      logic [31:0] r;
      logic hw;
      int k, x, y, z;
      r = 32'h0;
      hw = (o == 4'h5) || (o == 4'h7) || (o == 4'hb) || (o == 4'hd);
      case (o)
         4'h0: r = {a[7:0], a[15:8], a[23:16], a[31:24]};
         4'h1: r = {a[23:16], a[31:24], a[7:0], a[15:8]};
         4'h2: r = {{16{a[7]}}, a[7:0], a[15:8]};
         4'h3: for (k = 0; k < 32; k++) r[k] = a[31-k];
         4'h4: r = {m, d[15:0]};
         4'h9: r = {hv($signed(a[31:16]) + $signed(b[15:0])),
            hv($signed(a[15:0]) - $signed(b[31:16]))};
         4'ha: r = {hv($signed(a[15:0]) + $signed(b[31:16])),
            hv($signed(a[31:16]) - $signed(b[15:0]))};
         default: for (k = 0; k < 32; k += 8) begin
            if (!(hw && k[3])) begin
               x = hw ? $signed(a[k+:16]) : $signed(a[k+:8]);
               y = hw ? $signed(b[k+:16]) : $signed(b[k+:8]);
               z = (o > 4'ha) ? x - y : x + y;
               if (o inside {4'h7, 4'h8, 4'hb, 4'hc}) z = z >>> 1;
               if (hw) r[k+:16] = z[15:0];
               else r[k+:8] = z[7:0];
            end
         end
      endcase
      return r;
   endfunction
   // One operation: request, bounded wait for done, then judge done, wrote, illegal, flags, peek and, on a write, result
   task automatic run(input logic [3:0] o, c, f, a, b, d, input logic p,
      input logic [15:0] m, input logic w);
      logic [3:0] t;
      logic [31:0] e;
      int n;
      t = p ? d : a;
      e = model(o, sh[a], sh[b], sh[t], m);
      @(posedge clk);
      {op, cc, fl, ra, rb, rd, dp, imm, pk} <= {o, c, f, a, b, d, p, m, t};
      go <= 1'h1;
      @(posedge clk);
      go <= 1'h0;
      for (n = 0; n < 8 && done !== 1'h1; n++) begin
         @(posedge clk);
         #1;
      end
      chk(done, 1);
      chk(wrote, w);
      chk(illegal, 0);
      chk(flo, f);
      if (w) sh[t] = e;
      if (w) chk(res, e);
      chk(peek, sh[t]);
   endtask
   task automatic load(input logic [3:0] r, input logic [31:0] v);
      run(4'h4, 4'he, 4'h9, r, r, r, 1'h1, {v[7:0], v[15:8]}, 1'h1);
      run(4'h0, 4'he, 4'h6, r, r, r, 1'h1, 16'h0, 1'h1);
      run(4'h4, 4'hf, 4'hf, r, r, r, 1'h1, v[31:16], 1'h1);
      chk(sh[r], v);
   endtask
   task automatic t_reverse();
      run(4'h1, 4'he, 4'h3, 4'h1, 4'h0, 4'h3, 1'h1, 16'h0, 1'h1);
      run(4'h2, 4'he, 4'h3, 4'h1, 4'h0, 4'h4, 1'h1, 16'h0, 1'h1);
      run(4'h3, 4'he, 4'h3, 4'h1, 4'h0, 4'h5, 1'h1, 16'h0, 1'h1);
   endtask
   // Every parallel code on lanes at the sign and wrap boundaries
   task automatic t_parallel();
      logic [3:0] o;
      for (o = 4'h5; o <= 4'he; o++) run(o, 4'he, 4'ha, 4'h1, 4'h2, 4'h7, 1'h1, 16'h0, 1'h1);
   endtask
   task automatic t_omit();
      run(4'h5, 4'he, 4'h1, 4'h8, 4'h2, 4'h0, 1'h0, 16'h0, 1'h1);
   endtask
   // Zero flag decides EQ and NE; the failing ones must leave the register alone
   task automatic t_cond();
      run(4'hd, 4'h1, 4'h0, 4'h1, 4'h2, 4'h6, 1'h1, 16'h0, 1'h1);
      run(4'h5, 4'h0, 4'h0, 4'h1, 4'h2, 4'h6, 1'h1, 16'h0, 1'h0);
      run(4'h6, 4'h0, 4'h4, 4'h1, 4'h2, 4'h6, 1'h1, 16'h0, 1'h1);
      run(4'h5, 4'h1, 4'h4, 4'h1, 4'h2, 4'h6, 1'h1, 16'h0, 1'h0);
   endtask

   initial begin
      forever #5 clk = ~clk;
   end
   // Hang guard well above the roughly 150 cycles the sequence needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         errors++;
         tally_and_finish();
      end
   end
   initial begin
      foreach (sh[i]) sh[i] = 32'h0;
      repeat (16) @(posedge clk);
      rst <= 1'h0;
      load(4'h1, 32'h8123_4567);
      load(4'h2, 32'h7f80_01ff);
      load(4'h8, 32'h8000_7fff);
      t_reverse();
      t_parallel();
      t_omit();
      t_cond();
      tally_and_finish();
   end
endmodule
`default_nettype wire
